// ---- slpm_defines.vh ----
// register offsets, field positions and reset values for the position monitor
`ifndef SLPM_DEFINES_VH
`define SLPM_DEFINES_VH
`define SLPM_ADDR_CTRL 5'h00
`define SLPM_ADDR_CW1 5'h01
`define SLPM_ADDR_CW2 5'h02
`define SLPM_ADDR_SW1 5'h03
`define SLPM_ADDR_SW2 5'h04
`define SLPM_ADDR_DIAG 5'h05
`define SLPM_ADDR_UP0 5'h06
`define SLPM_ADDR_LO0 5'h07
`define SLPM_ADDR_UP1 5'h08
`define SLPM_ADDR_LO1 5'h09
`define SLPM_ADDR_RESP 5'h0a
`define SLPM_ADDR_POS 5'h0b
`define SLPM_ADDR_IRQST 5'h0c
`define SLPM_ADDR_IRQMSK 5'h0d
`define SLPM_ADDR_ENREQ 5'h0e
// fields of the safety function enable word
`define SLPM_EN_LPM 1
`define SLPM_EN_SYNC 3
// control word bits
`define SLPM_CW_SEL 6
`define SLPM_CW_RANGE 19
// status word bits
`define SLPM_SW_ACTIVE 6
`define SLPM_SW_RANGE 19
`define SLPM_SW_SAFEPOS 23
`define SLPM_SW_UPOK 30
`define SLPM_SW_LOOK 31
// ctrl register fields
`define SLPM_CTRL_ACK 0
`define SLPM_CTRL_TG30 1
`define SLPM_CTRL_FSI 2
`define SLPM_CTRL_REF 3
`define SLPM_CTRL_COMMFAIL 4
`define SLPM_CTRL_POWERON 5
// interrupt status bits
`define SLPM_IRQ_VIOL 0
`define SLPM_IRQ_CFG 1
`define SLPM_IRQ_RETRACT 2
// stop response threshold for delayed pulse suppression
`define SLPM_RESP_DELAYED 8'h0a
`define SLPM_RESP_RESET 8'h01
`define SLPM_RESP_A 8'h00
`define SLPM_RESP_E 8'h04
`define SLPM_RESP_DA 8'h0a
`define SLPM_RESP_DE 8'h0e
`define SLPM_ENREQ_RESET 32'h0000_0000
`endif

// ---- slpm_monitor.v ----
// limited position monitor with axi4-lite register slave
`timescale 1ns/10ps
`include "slpm_defines.vh"
module slpm_monitor #(
    parameter POS_W = 32
) (
    input wire aclk, // 200 mhz clock
    input wire aresetn, // synchronous reset, active low
    input wire [6:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output wire s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write byte strobes
    input wire s_axi_wvalid, // write data valid
    output wire s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [6:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output wire s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    input wire [POS_W-1:0] position, // safe actual position
    input wire failsafe_input_select, // selection terminal
    input wire failsafe_input_range, // range terminal
    input wire retract_input_select, // retract terminal
    output reg stop_request, // stop response active
    output reg [7:0] stop_category, // stop category to apply
    output reg limit_message, // limit violation message
    output reg config_fault, // monitor with synchronization fault
    output reg retract_reaction, // retract on communication loss
    output reg retract_active, // retraction under way
    output reg direction_monitor_pos, // select positive direction
    output reg direction_monitor_neg, // select negative direction
    output reg failsafe_output_active, // safe state monitor active
    output wire irq // level interrupt
);
    // overview: software loads the limit pairs, the stop response and
    // the enables, then raises the power-on level; the control words
    // or the terminals then select the monitor and the range. while
    // selected and safely referenced, the position is compared with
    // the active pair on every clock. a crossing is latched and drives
    // stop_request and limit_message until an acknowledge arrives with
    // the position back inside the active pair or the monitor
    // deselected. retraction, started from the terminal, deselects the
    // monitor and points the direction monitor at the permitted side.

    // register map, byte address is four times the word index:
    //   0x00 control: acknowledge pulse, short telegram, terminal
    //        control, safely referenced, bus loss, power-on level
    //   0x04 first safety control word, 0x08 second control word
    //   0x0c and 0x10 safety status words, read only
    //   0x14 diagnostics, read only
    //   0x18 to 0x24 upper and lower limits of range one and two
    //   0x28 stop response, 0x2c live position, read only
    //   0x30 interrupt status, write one to clear, 0x34 its mask
    //   0x38 enables that take effect at the next power-on; any nonzero word gates bus loss retract at once
    // unmapped words answer with a slave error and change nothing
    reg [31:0] ctrl; // control and command bits
    reg [31:0] cw1; // first safety control word
    reg [31:0] cw2; // second safety control word
    reg [31:0] enreq; // enables waiting for power-on
    reg [31:0] enables; // live enables, copied at power-on
    reg [POS_W-1:0] up0; // upper limit, range one
    reg [POS_W-1:0] lo0; // lower limit, range one
    reg [POS_W-1:0] up1; // upper limit, range two
    reg [POS_W-1:0] lo1; // lower limit, range two
    reg [7:0] resp; // configured stop response
    reg [2:0] irq_status; // sticky events
    reg [2:0] irq_mask; // events allowed onto irq
    // monitor state
    reg latched; // limit violation held until acknowledged
    reg viol_upper; // last violation was on the upper limit
    reg retract_prev; // retract pin one clock back
    reg power_prev; // power-on level one clock back
    // write channel holding registers
    reg aw_held; // write address taken, waiting
    reg w_held; // write data taken, waiting
    reg [6:0] aw_addr; // held write address
    reg [31:0] w_data; // held write data
    reg [3:0] w_strb; // held byte strobes

    // merge byte lanes into an old word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // byte address to word index; the low two bits are ignored since
    // every register is one aligned word
    function [4:0] word_idx;
        input [6:0] addr;
        begin
            word_idx = addr[6:2];
        end
    endfunction

    // control source and selection decode
    // the control bits are plain levels, so they act on the next clock
    wire tg30 = ctrl[`SLPM_CTRL_TG30];
    wire via_fsi = ctrl[`SLPM_CTRL_FSI];
    wire referenced = ctrl[`SLPM_CTRL_REF];
    wire comm_fail = ctrl[`SLPM_CTRL_COMMFAIL];
    wire enabled = enables[`SLPM_EN_LPM];
    wire bus_sel = cw1[`SLPM_CW_SEL] | cw2[`SLPM_CW_SEL];
    // telegram 30 forces range one
    wire bus_range = tg30 ? 1'b0 : cw2[`SLPM_CW_RANGE];
    // one source only: mixing bus and terminal commands would let a
    // stale control word keep the monitor selected
    wire sel = enabled & (via_fsi ? failsafe_input_select
                                  : bus_sel);
    // retraction deselects the monitor while it runs
    wire selected = sel & ~retract_active;
    wire range = via_fsi ? failsafe_input_range : bus_range;
    wire active = selected & referenced;
    wire [POS_W-1:0] up_lim = range ? up1 : up0;
    wire [POS_W-1:0] lo_lim = range ? lo1 : lo0;
    // plain comparisons, no hysteresis
    // a position jittering on a limit makes these flags toggle each
    // sample; a filter here would hide a real crossing for a while
    // the limits are inclusive: sitting on a limit is still allowed
    wire up_ok = ~($signed(position) > $signed(up_lim));
    wire lo_ok = ~($signed(position) < $signed(lo_lim));
    wire violation = active & ~(up_ok & lo_ok);
    // acknowledge clears only when the cause has gone
    wire ack_ok = ~violation | ~selected;
    // a rising retract pin while a violation is held starts retraction;
    // it is only honoured under terminal control and once referenced,
    // since a direction monitor needs a trusted position
    wire retract_start = via_fsi & retract_input_select & ~retract_prev &
                         latched & referenced;

    wire [6:0] diag = {lo_ok, up_ok, referenced, range & active,
                       active, range, sel};
    // status words; the short telegram keeps only bit 6, as it has no
    // room for the range and limit feedback
    wire [31:0] sw2 = tg30 ? {25'h0, active, 6'h00} :
        ({31'h0, 1'b0} |
         ({31'h0, active} << `SLPM_SW_ACTIVE) |
         ({31'h0, active & range} << `SLPM_SW_RANGE) |
         ({31'h0, referenced} << `SLPM_SW_SAFEPOS) |
         ({31'h0, up_ok} << `SLPM_SW_UPOK) |
         ({31'h0, lo_ok} << `SLPM_SW_LOOK));
    // the first status word carries only the active bit
    wire [31:0] sw1 = {25'h0, active, 6'h00};

    // axi handshake: hold each channel until both have arrived
    // address and data may come in either order; the register update
    // waits for both and for the previous response to be taken, so a
    // slow bready stalls the next write rather than losing a response
    // reads answer one clock after the address is taken
    assign s_axi_awready = ~aw_held;
    assign s_axi_wready = ~w_held;
    assign s_axi_arready = ~s_axi_rvalid;
    wire wr_go = aw_held & w_held & ~s_axi_bvalid;
    wire [4:0] wr_idx = word_idx(aw_addr);
    wire ack_write = wr_go && wr_idx == `SLPM_ADDR_CTRL &&
                     w_strb[0] && w_data[`SLPM_CTRL_ACK];
    // interrupt events and the software clear of the sticky bits
    wire irq_wr = wr_go && wr_idx == `SLPM_ADDR_IRQST && w_strb[0];
    wire [2:0] irq_clear = irq_wr ? w_data[2:0] : 3'h0;
    wire [2:0] irq_set = {retract_start, config_fault, violation};

    // register writes and monitor state
    always @(posedge aclk) begin
        if (!aresetn) begin
            // every register has a defined value after reset
            ctrl <= 32'h0;
            cw1 <= 32'h0;
            cw2 <= 32'h0;
            enreq <= `SLPM_ENREQ_RESET;
            enables <= `SLPM_ENREQ_RESET;
            up0 <= {POS_W{1'b0}};
            lo0 <= {POS_W{1'b0}};
            up1 <= {POS_W{1'b0}};
            lo1 <= {POS_W{1'b0}};
            resp <= `SLPM_RESP_RESET;
            irq_mask <= 3'h0;
            irq_status <= 3'h0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 7'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            // monitor state: no violation held, no retraction
            latched <= 1'b0;
            viol_upper <= 1'b0;
            retract_prev <= 1'b0;
            retract_active <= 1'b0;
            power_prev <= 1'b0;
            config_fault <= 1'b0;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                // the word lands the edge after both halves are held
                case (wr_idx)
                    `SLPM_ADDR_CTRL: ctrl <= merge(ctrl, w_data, w_strb);
                    `SLPM_ADDR_CW1: cw1 <= merge(cw1, w_data, w_strb);
                    `SLPM_ADDR_CW2: cw2 <= merge(cw2, w_data, w_strb);
                    `SLPM_ADDR_UP0: up0 <= merge(up0, w_data, w_strb);
                    `SLPM_ADDR_LO0: lo0 <= merge(lo0, w_data, w_strb);
                    `SLPM_ADDR_UP1: up1 <= merge(up1, w_data, w_strb);
                    `SLPM_ADDR_LO1: lo1 <= merge(lo1, w_data, w_strb);
                    `SLPM_ADDR_RESP: begin
                        if (w_strb[0]) begin
                            resp <= w_data[7:0];
                        end
                    end
                    `SLPM_ADDR_ENREQ:
                        enreq <= merge(enreq, w_data, w_strb);
                    `SLPM_ADDR_IRQMSK: begin
                        if (w_strb[0]) begin
                            irq_mask <= w_data[2:0];
                        end
                    end
                    // read-only words and the w1c status take no plain write
                    `SLPM_ADDR_IRQST, `SLPM_ADDR_SW1, `SLPM_ADDR_SW2,
                    `SLPM_ADDR_DIAG, `SLPM_ADDR_POS: ;
                    default: s_axi_bresp <= 2'b10;
                endcase
            end
            // acknowledge is a self-clearing command bit
            // one clock long, so a held bit cannot clear a later violation
            if (!ack_write) begin
                ctrl[`SLPM_CTRL_ACK] <= 1'b0;
            end
            // new enables only land on a rising power-on level
            // a level held high must not copy the enables again
            power_prev <= ctrl[`SLPM_CTRL_POWERON];
            if (ctrl[`SLPM_CTRL_POWERON] && !power_prev) begin
                enables <= enreq;
                config_fault <= enreq[`SLPM_EN_LPM] &
                                enreq[`SLPM_EN_SYNC];
            end
            // violation latch; bare acknowledge keeps drive held
            // the set wins every cycle the crossing stands, so an
            // acknowledge during a violation is lost on purpose
            if (violation) begin
                latched <= 1'b1;
                viol_upper <= ~up_ok;
            end else if (ctrl[`SLPM_CTRL_ACK] && ack_ok) begin
                latched <= 1'b0;
            end
            // retract input edges; only the start edge needs failsafe input control
            retract_prev <= retract_input_select;
            if (retract_start) begin
                retract_active <= 1'b1;
            end else if (!retract_input_select && retract_prev) begin
                retract_active <= 1'b0;
            end
            // interrupt status: a set beats a same-cycle clear
            irq_status <= (irq_status & ~irq_clear) | irq_set;
        end
    end
    assign irq = |(irq_status & irq_mask);

    // stop response and message outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            stop_request <= 1'b0;
            stop_category <= 8'h00;
            limit_message <= 1'b0;
            retract_reaction <= 1'b0;
            direction_monitor_pos <= 1'b0;
            direction_monitor_neg <= 1'b0;
            failsafe_output_active <= 1'b0;
        end else begin
            // a held violation keeps the drive stopped after the position
            // returns, until an acknowledge is accepted
            // a configuration fault has its own pin and no stop here
            stop_request <= latched | violation;
            stop_category <= resp;
            limit_message <= latched | violation;
            // bus loss retract only with delayed response
            retract_reaction <= comm_fail & active & (|enreq) &
                                (resp >= `SLPM_RESP_DELAYED);
            // lower crossing retracts upward, upper one downward
            direction_monitor_pos <= retract_active & ~viol_upper;
            direction_monitor_neg <= retract_active & viol_upper;
            // the safe output follows the same referenced active level
            failsafe_output_active <= active;
        end
    end

    // read channel, one cycle answer
    // read data is captured once and held while rvalid waits
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (word_idx(s_axi_araddr))
                `SLPM_ADDR_CTRL: s_axi_rdata <= ctrl;
                `SLPM_ADDR_CW1: s_axi_rdata <= cw1;
                `SLPM_ADDR_CW2: s_axi_rdata <= cw2;
                `SLPM_ADDR_SW1: s_axi_rdata <= sw1;
                `SLPM_ADDR_SW2: s_axi_rdata <= sw2;
                `SLPM_ADDR_DIAG: s_axi_rdata <= {23'h0, latched,
                                                 config_fault, diag};
                `SLPM_ADDR_UP0: s_axi_rdata <= up0;
                `SLPM_ADDR_LO0: s_axi_rdata <= lo0;
                `SLPM_ADDR_UP1: s_axi_rdata <= up1;
                `SLPM_ADDR_LO1: s_axi_rdata <= lo1;
                `SLPM_ADDR_RESP: s_axi_rdata <= {24'h0, resp};
                `SLPM_ADDR_POS: s_axi_rdata <= position;
                `SLPM_ADDR_IRQST: s_axi_rdata <= {29'h0, irq_status};
                `SLPM_ADDR_IRQMSK: s_axi_rdata <= {29'h0, irq_mask};
                `SLPM_ADDR_ENREQ: s_axi_rdata <= enreq;
                // unmapped words read as zero with a slave error
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end
    end
endmodule // slpm_monitor

// ---- slpm_chk_monitor.sv ----
// concurrent checks on the position monitor ports
`timescale 1ns/10ps
module slpm_chk (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, active low
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b resp
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic stop_request, // stop
    input wire logic limit_message, // message
    input wire logic config_fault, // cfg fault
    input wire logic retract_active, // retract
    input wire logic direction_monitor_pos, // dir pos
    input wire logic direction_monitor_neg, // dir neg
    input wire logic irq // interrupt
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // answers must stand until the master takes them
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data moved");
    property p_bresp; s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10};
    endproperty
    a_bresp: assert property (p_bresp) else $error("bad bresp");
    property p_awdrop; s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
    endproperty
    a_awdrop: assert property (p_awdrop) else $error("awready stayed");
    property p_wresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:3] s_axi_bvalid; endproperty
    a_wresp: assert property (p_wresp) else $error("no write answer");
    property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rresp: assert property (p_rresp) else $error("no read answer");
    property p_armask; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_armask: assert property (p_armask) else $error("ar taken early");
    property p_msg; $rose(stop_request) |-> limit_message; endproperty
    a_msg: assert property (p_msg) else $error("stop without msg");
    property p_dir; retract_active |->
        !(direction_monitor_pos && direction_monitor_neg); endproperty
    a_dir: assert property (p_dir) else $error("both directions");
    property p_dirset; $rose(retract_active) |->
        ##[0:2] (direction_monitor_pos || direction_monitor_neg); endproperty
    a_dirset: assert property (p_dirset) else $error("no dir");
    c_stop: cover property (stop_request);
    c_retr: cover property (retract_active);
    c_irq: cover property (irq);
    c_cfg: cover property (config_fault);
endmodule // slpm_chk
bind slpm_monitor slpm_chk i_chk (.*);

// ---- slpm_fsterm.sv ----
// failsafe terminal model driving the monitor's input pins
`timescale 1ns/10ps
module slpm_fsterm (
    input wire logic aclk, // clock
    input wire logic cmd_sel, // wanted select level
    input wire logic cmd_rng, // wanted range level
    input wire logic cmd_rtr, // wanted retract level
    output logic failsafe_input_select = 1'b0, // select pin
    output logic failsafe_input_range = 1'b0, // range pin
    output logic retract_input_select = 1'b0 // retract pin
);
    // terminals change one clock late, as a real input filter would
    always @(posedge aclk) begin
        failsafe_input_select <= cmd_sel;
        failsafe_input_range <= cmd_rng;
        retract_input_select <= cmd_rtr;
    end
endmodule // slpm_fsterm

// ---- tb_top.sv ----
// self-checking bench for the limited position monitor
`timescale 1ns/10ps
module tb_top;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [6:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_v;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, stop_request, limit_message, config_fault, irq;
    logic retract_reaction, retract_active, failsafe_output_active;
    logic direction_monitor_pos, direction_monitor_neg, ha, hw;
    logic failsafe_input_select, failsafe_input_range, retract_input_select;
    logic cmd_sel = 0, cmd_rng = 0, cmd_rtr = 0;
    logic [31:0] position = 0;
    logic [7:0] stop_category;
    integer num_errors = 0, num_checks = 0;
    slpm_monitor i_dut (.*);
    slpm_fsterm i_term (.*);
    initial forever #2.5 aclk = ~aclk;
    task report_and_stop;
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input [95:0] nm, input [31:0] s, input [31:0] e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %0s exp %h seen %h", nm, e, s);
        end
    endtask
    // readiness is looked at mid-cycle, so it is the value the edge sees
    task wr(input [6:0] a, input [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(negedge aclk);
            ha = s_axi_awvalid & s_axi_awready;
            hw = s_axi_wvalid & s_axi_wready;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 0;
            if (hw) s_axi_wvalid <= 0;
        end while (s_axi_awvalid & !ha | s_axi_wvalid & !hw);
        do begin @(negedge aclk); ha = s_axi_bvalid; @(posedge aclk); end
        while (!ha);
        s_axi_bready <= 0;
    endtask
    task rd(input [6:0] a);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin @(negedge aclk); ha = s_axi_arready; @(posedge aclk); end
        while (!ha);
        s_axi_arvalid <= 0;
        do begin
            @(negedge aclk);
            {ha, rd_v, rr} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
        end while (!ha);
        s_axi_rready <= 0;
    endtask
    task st; repeat (4) @(posedge aclk); endtask
    task t_enable;
        rd(7'h28); chk("resp rst", rd_v, 32'h1);
        rd(7'h10); chk("sw2 rst", rd_v, 32'hc0000000);
        wr(7'h18, 32'd100); wr(7'h1c, 32'hffffff9c);
        wr(7'h20, 32'd1000); wr(7'h24, 32'h0);
        wr(7'h38, 32'h2); wr(7'h04, 32'h40); wr(7'h00, 32'h08);
        rd(7'h10); chk("sw2 nopwr", rd_v, 32'hc0800000);
        wr(7'h00, 32'h28); st;
        rd(7'h10); chk("sw2 on", rd_v, 32'hc0800040);
    endtask
    task t_violation;
        wr(7'h28, 32'h0e); wr(7'h34, 32'h1);
        position <= 32'd100; st;
        rd(7'h10); chk("sw2 edge", rd_v, 32'hc0800040);
        position <= 32'd101; st;
        chk("stop", stop_request, 1);
        chk("msg", limit_message, 1);
        chk("cat", stop_category, 8'h0e);
        chk("irq", irq, 1);
        rd(7'h10); chk("sw2 viol", rd_v, 32'h80800040);
        wr(7'h00, 32'h29); st;
        chk("ack only", stop_request, 1);
        wr(7'h08, 32'h00080040); wr(7'h00, 32'h29); st;
        chk("ack ok", stop_request, 0);
        rd(7'h10); chk("sw2 rng1", rd_v, 32'hc0880040);
        wr(7'h30, 32'h1); st; chk("irq clr", irq, 0);
    endtask
    task t_retract;
        cmd_sel <= 1; wr(7'h00, 32'h2c); position <= 32'hffffff9b; st;
        chk("fs stop", stop_request, 1);
        cmd_rtr <= 1; st;
        chk("rtr on", retract_active, 1);
        chk("dir pos", direction_monitor_pos, 1);
        chk("dir neg", direction_monitor_neg, 0);
        chk("fs out rtr", failsafe_output_active, 0);
        rd(7'h30); chk("irq rtr", rd_v, 32'h5);
        position <= 0; wr(7'h00, 32'h2d); cmd_rtr <= 0; st;
        chk("rtr off", retract_active, 0);
        chk("fs clear", stop_request, 0);
        chk("fs out", failsafe_output_active, 1);
    endtask
    task t_comm;
        wr(7'h28, 32'h04); wr(7'h00, 32'h3c); st;
        chk("esr low", retract_reaction, 0);
        wr(7'h00, 32'h2c); wr(7'h28, 32'h0a); wr(7'h00, 32'h3c); st;
        chk("esr hi", retract_reaction, 1);
        wr(7'h00, 32'h2c);
    endtask
    task t_misc;
        rd(7'h7c); chk("unmapped", rr, 2'b10);
        wr(7'h04, 32'h40); wr(7'h08, 32'h00080040); wr(7'h00, 32'h2a);
        rd(7'h10); chk("tg30", rd_v, 32'h40);
        wr(7'h38, 32'ha); wr(7'h00, 32'h08); wr(7'h00, 32'h28); st;
        chk("cfg", config_fault, 1);
    endtask
    initial begin
        #200000;
        num_errors++;
        report_and_stop;
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        t_enable;
        t_violation;
        t_retract;
        t_comm;
        t_misc;
        report_and_stop;
    end
endmodule // tb_top
